// ### core/cpw_unit.sv
`timescale 1ns/10ps
module cpw_unit
    import cpw_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    // unit pin
    input  wire logic              unitPinIn,
    output logic                   unitPinOut,
    output logic                   unitPinOe,
    // first timer and converter hooks
    input  wire logic              timer1Tick,
    input  wire logic              adcEnable,
    output logic                   adcStart
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] readdata_q;
    logic              waitrequest_q;
    logic [7:0]        control_q;
    logic [7:0]        valueLow_q;
    logic [7:0]        valueHigh_q;
    logic [1:0]        dutyFrac_q;
    logic [15:0]       timer1_q;
    logic [7:0]        timer2_q;
    logic [6:0]        t2Control_q;
    logic [7:0]        t2Period_q;
    logic [3:0]        t2Pre_q;
    logic [3:0]        t2Post_q;
    logic [1:0]        qPhase_q;
    logic [3:0]        capPre_q;
    logic [2:0]        flags_q;
    logic [2:0]        enables_q;
    logic              pinPrev_q;
    logic              cmpEqual_q;
    logic              pinLatch_q;
    logic              pinOe_q;
    logic              adcStart_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire logic [7:0] regIdx     = address[9:2];
    wire logic       busReq     = read | write;
    wire logic       wrCommit   = write & ~waitrequest_q;
    wire logic [7:0] wd         = writedata[7:0];
    wire logic       wrFlags    = wrCommit && (regIdx == IDX_IRQ_FLAGS);
    wire logic       wrT1Low    = wrCommit && (regIdx == IDX_T1_LOW);
    wire logic       wrT1High   = wrCommit && (regIdx == IDX_T1_HIGH);
    wire logic       wrT2Count  = wrCommit && (regIdx == IDX_T2_COUNT);
    wire logic       wrT2Ctrl   = wrCommit && (regIdx == IDX_T2_CONTROL);
    wire logic       wrValLow   = wrCommit && (regIdx == IDX_VALUE_LOW);
    wire logic       wrValHigh  = wrCommit && (regIdx == IDX_VALUE_HIGH);
    wire logic       wrControl  = wrCommit && (regIdx == IDX_CONTROL);
    wire logic       wrEnables  = wrCommit && (regIdx == IDX_IRQ_ENABLES);
    wire logic       wrPeriod   = wrCommit && (regIdx == IDX_T2_PERIOD);

    wire logic [7:0] rdMux =
        (regIdx == IDX_IRQ_FLAGS)   ? {5'h00, flags_q}     :
        (regIdx == IDX_T1_LOW)      ? timer1_q[7:0]        :
        (regIdx == IDX_T1_HIGH)     ? timer1_q[15:8]       :
        (regIdx == IDX_T2_COUNT)    ? timer2_q             :
        (regIdx == IDX_T2_CONTROL)  ? {1'b0, t2Control_q}  :
        (regIdx == IDX_VALUE_LOW)   ? valueLow_q           :
        (regIdx == IDX_VALUE_HIGH)  ? valueHigh_q          :
        (regIdx == IDX_CONTROL)     ? {2'h0, control_q[5:0]} :
        (regIdx == IDX_IRQ_ENABLES) ? {5'h00, enables_q}   :
        (regIdx == IDX_T2_PERIOD)   ? t2Period_q           : 8'h00;

    // ------------------------------------------------------------
    // mode and pin edges
    // ------------------------------------------------------------
    wire logic [3:0] mode      = control_q[3:0];
    wire logic       capMode   = isCapture(mode);
    wire logic       cmpMode   = isCompare(mode);
    wire logic       pwmMode   = isPwm(mode);
    wire logic       pinRise   = unitPinIn & ~pinPrev_q;
    wire logic       pinFall   = ~unitPinIn & pinPrev_q;

    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    wire logic capEdge  = capMode && ((mode == MODE_CAP_FALL) ? pinFall : pinRise);
    wire logic capLast  = (mode == MODE_CAP_DIV4) ? (capPre_q[1:0] == CAP_DIV4_LAST)
                                                  : (capPre_q == CAP_DIV16_LAST);
    wire logic capDiv   = (mode == MODE_CAP_DIV4) || (mode == MODE_CAP_DIV16);
    wire logic capEvent = capEdge && (!capDiv || capLast);

    // ------------------------------------------------------------
    // compare
    // ------------------------------------------------------------
    wire logic [15:0] compareValue = {valueHigh_q, valueLow_q};
    wire logic        cmpEqual     = cmpMode && (compareValue == timer1_q);
    // one hit per arrival at equality
    wire logic        cmpHit       = cmpEqual && !cmpEqual_q;
    wire logic        trigHit      = cmpHit && (mode == MODE_CMP_TRIG);

    // ------------------------------------------------------------
    // first timer
    // ------------------------------------------------------------
    // trigger clear never counts as overflow
    wire logic t1Overflow = timer1Tick && (timer1_q == 16'hFFFF) && !trigHit
                            && !wrT1Low && !wrT1High;

    // ------------------------------------------------------------
    // second timer
    // ------------------------------------------------------------
    wire logic [1:0] prescale = t2Control_q[1:0];
    wire logic [3:0] outScale = t2Control_q[6:3];
    wire logic       t2On     = t2Control_q[T2_ON_BIT];
    wire logic       instTick = qPhase_q == Q_PHASE_LAST;
    wire logic       preDone  = (prescale == PRESCALE_1) ? 1'b1 :
                                (prescale == PRESCALE_4) ? (t2Pre_q[1:0] == PRE4_LAST) :
                                (t2Pre_q == PRE16_LAST);
    wire logic       t2Inc    = instTick && t2On && preDone;
    wire logic       t2Wrap   = t2Inc && (timer2_q == t2Period_q);
    wire logic       t2Clear  = wrT2Count || wrT2Ctrl;
    wire logic       t2FlagHit = t2Wrap && (t2Post_q == outScale);
    // two extension bits below the timer
    wire logic [1:0] extBits  = (prescale == PRESCALE_1) ? qPhase_q :
                                (prescale == PRESCALE_4) ? t2Pre_q[1:0] : t2Pre_q[3:2];

    // ------------------------------------------------------------
    // pwm
    // ------------------------------------------------------------
    // duty from low value and fraction bits
    wire logic [9:0] dutyNext  = {valueLow_q, control_q[5:4]};
    wire logic [9:0] dutyLive  = {valueHigh_q, dutyFrac_q};
    // duty count steps only where the extension bits change
    wire logic       extStep   = t2On && ((prescale == PRESCALE_1) ? 1'b1 :
                                 (prescale == PRESCALE_4) ? instTick :
                                 (instTick && (t2Pre_q[1:0] == PRE4_LAST)));
    // latch is registered: clear one step ahead so high time equals duty
    wire logic [9:0] dutyCount = {timer2_q, extBits} + 10'h001;
    // oversized duty never equals the count
    wire logic       pwmClear  = pwmMode && extStep && (dutyLive == dutyCount);
    wire logic       pwmReload = pwmMode && t2Wrap;

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            waitrequest_q <= 1'b1;
            readdata_q    <= '0;
        end else begin
            waitrequest_q <= !(busReq && waitrequest_q);
            readdata_q    <= {24'h000000, rdMux};
        end
    end

    // ------------------------------------------------------------
    // control, period and enables
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            control_q   <= CONTROL_RST;
            t2Control_q <= T2_CONTROL_RST;
            t2Period_q  <= T2_PERIOD_RST;
            enables_q   <= '0;
        end else begin
            if (wrControl) begin
                control_q <= {2'h0, wd[5:0]};
            end
            if (wrT2Ctrl) begin
                t2Control_q <= wd[6:0];
            end
            if (wrPeriod) begin
                t2Period_q <= wd;
            end
            if (wrEnables) begin
                enables_q <= wd[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // value registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            valueLow_q  <= '0;
            valueHigh_q <= '0;
            dutyFrac_q  <= '0;
        end else if (capEvent) begin
            valueLow_q  <= timer1_q[7:0];
            valueHigh_q <= timer1_q[15:8];
        end else begin
            if (wrValLow) begin
                valueLow_q <= wd;
            end
            // high value frozen by software in pwm
            if (pwmReload) begin
                valueHigh_q <= dutyNext[9:2];
                dutyFrac_q  <= dutyNext[1:0];
            end else if (wrValHigh && !pwmMode) begin
                valueHigh_q <= wd;
            end
        end
    end

    // ------------------------------------------------------------
    // capture prescaler
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            capPre_q <= '0;
        end else if (!capMode) begin
            capPre_q <= '0;
        end else if (capEdge && capDiv) begin
            capPre_q <= capLast ? 4'h0 : capPre_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // first timer count
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer1_q   <= '0;
            cmpEqual_q <= 1'b0;
        end else begin
            cmpEqual_q <= cmpEqual;
            if (wrT1Low) begin
                timer1_q[7:0] <= wd;
            end else if (wrT1High) begin
                timer1_q[15:8] <= wd;
            end else if (trigHit) begin
                timer1_q <= '0;
            end else if (timer1Tick) begin
                timer1_q <= timer1_q + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // second timer, prescaler, postscaler
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            qPhase_q <= '0;
            timer2_q <= T2_COUNT_RST;
            t2Pre_q  <= '0;
            t2Post_q <= '0;
        end else begin
            qPhase_q <= qPhase_q + 2'h1;
            if (wrT2Count) begin
                timer2_q <= wd;
            end else if (t2Wrap) begin
                timer2_q <= '0;
            end else if (t2Inc) begin
                timer2_q <= timer2_q + 8'h01;
            end
            if (t2Clear) begin
                t2Pre_q  <= '0;
                t2Post_q <= '0;
            end else begin
                if (instTick && t2On) begin
                    t2Pre_q <= t2Pre_q + 4'h1;
                end
                if (t2Wrap) begin
                    t2Post_q <= t2FlagHit ? 4'h0 : t2Post_q + 4'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // flags: hardware set wins over software clear
    // ------------------------------------------------------------
    wire logic [2:0] flagSet = {capEvent | cmpHit, t2FlagHit, t1Overflow};
    wire logic [2:0] flagHold = wrFlags ? wd[2:0] : flags_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flags_q <= '0;
        end else begin
            flags_q <= flagHold | flagSet;
        end
    end

    // ------------------------------------------------------------
    // pin latch and trigger output
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pinLatch_q <= 1'b0;
            pinOe_q    <= 1'b0;
            pinPrev_q  <= 1'b0;
            adcStart_q <= 1'b0;
        end else begin
            pinPrev_q  <= unitPinIn;
            pinOe_q    <= cmpMode || pwmMode;
            adcStart_q <= trigHit && adcEnable;
            if (wrControl && (wd == CONTROL_RST)) begin
                pinLatch_q <= 1'b0;
            end else if (cmpHit && (mode == MODE_CMP_SET)) begin
                pinLatch_q <= 1'b1;
            end else if (cmpHit && (mode == MODE_CMP_CLEAR)) begin
                pinLatch_q <= 1'b0;
            // period start sets pin unless zero duty
            end else if (pwmReload) begin
                pinLatch_q <= dutyNext != 10'h000;
            end else if (pwmClear) begin
                pinLatch_q <= 1'b0;
            end
            // soft and trigger modes leave the latch
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign readdata    = readdata_q;
    assign waitrequest = waitrequest_q;
    assign unitPinOut  = pinLatch_q;
    assign unitPinOe   = pinOe_q;
    assign adcStart    = adcStart_q;

endmodule : cpw_unit

// ### core/cpw_pkg.sv
package cpw_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int         ADDR_W   = 10;
    localparam int         DATA_W   = 32;

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0C;
    localparam logic [7:0] IDX_T1_LOW      = 8'h0E;
    localparam logic [7:0] IDX_T1_HIGH     = 8'h0F;
    localparam logic [7:0] IDX_T2_COUNT    = 8'h11;
    localparam logic [7:0] IDX_T2_CONTROL  = 8'h12;
    localparam logic [7:0] IDX_VALUE_LOW   = 8'h15;
    localparam logic [7:0] IDX_VALUE_HIGH  = 8'h16;
    localparam logic [7:0] IDX_CONTROL     = 8'h17;
    localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
    localparam logic [7:0] IDX_T2_PERIOD   = 8'h92;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int         FLAG_EVENT_BIT  = 2;
    localparam int         FLAG_T2_BIT     = 1;
    localparam int         FLAG_T1_BIT     = 0;
    localparam int         T2_ON_BIT       = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RST     = 8'h00;
    localparam logic [6:0] T2_CONTROL_RST  = 7'h00;
    localparam logic [7:0] T2_COUNT_RST    = 8'h00;
    localparam logic [7:0] T2_PERIOD_RST   = 8'hFF;

    // ------------------------------------------------------------
    // mode field encodings
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_OFF        = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
    localparam logic [3:0] MODE_CAP_DIV4   = 4'h6;
    localparam logic [3:0] MODE_CAP_DIV16  = 4'h7;
    localparam logic [3:0] MODE_CMP_SET    = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR  = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT   = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG   = 4'hB;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam logic [1:0] Q_PHASE_LAST    = 2'h3;
    localparam logic [1:0] CAP_DIV4_LAST   = 2'h3;
    localparam logic [3:0] CAP_DIV16_LAST  = 4'hF;
    localparam logic [1:0] PRE4_LAST       = 2'h3;
    localparam logic [3:0] PRE16_LAST      = 4'hF;
    localparam logic [1:0] PRESCALE_1      = 2'h0;
    localparam logic [1:0] PRESCALE_4      = 2'h1;

    // ------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------
    function automatic logic isCapture(input logic [3:0] mode);
        return mode[3:2] == 2'h1;
    endfunction : isCapture

    function automatic logic isCompare(input logic [3:0] mode);
        return mode[3:2] == 2'h2;
    endfunction : isCompare

    function automatic logic isPwm(input logic [3:0] mode);
        return mode[3:2] == 2'h3;
    endfunction : isPwm

endpackage : cpw_pkg

// ### tb/cpw_sva.sv
`timescale 1ns/10ps
module cpw_sva
    import cpw_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // bus
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    input  wire logic [DATA_W-1:0] readdata,
    input  wire logic              waitrequest,
    // pin and hooks
    input  wire logic              unitPinOut,
    input  wire logic              unitPinOe,
    input  wire logic              adcEnable,
    input  wire logic              adcStart
);
    // ----
    // mode shadow from committed writes
    // ----
    logic [3:0] modeQ;
    logic       ctlWr;
    assign ctlWr = write && !waitrequest && address[9:2] == IDX_CONTROL;
    always_ff @(posedge ref_clk) begin
        if (reset)
            modeQ <= MODE_OFF;
        else if (ctlWr)
            modeQ <= writedata[3:0];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer after one wait cycle");
    upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    zero_clears_a: assert property (ctlWr && writedata[7:0] == 8'h00 |=> ##1 !unitPinOut && !unitPinOe)
        else $error("pin latch not low after control cleared");
    oe_mode_a: assert property ($past(modeQ) == modeQ |-> unitPinOe == modeQ[3])
        else $error("output enable does not follow mode");
    soft_hold_a: assert property ((modeQ == MODE_CMP_SOFT || modeQ == MODE_CMP_TRIG) &&
        $past(modeQ) == modeQ |-> $stable(unitPinOut)) else $error("pin moved in no-pin mode");
    set_rise_a: assert property (modeQ == MODE_CMP_SET && $past(modeQ) == modeQ
        |-> !$fell(unitPinOut)) else $error("pin fell in set mode");
    clear_fall_a: assert property (modeQ == MODE_CMP_CLEAR && $past(modeQ) == modeQ
        |-> !$rose(unitPinOut)) else $error("pin rose in clear mode");
    adc_cause_a: assert property (adcStart |-> modeQ == MODE_CMP_TRIG && $past(adcEnable))
        else $error("conversion start without trigger");
    adc_pulse_a: assert property (adcStart |=> !adcStart)
        else $error("conversion start longer than one cycle");
endmodule : cpw_sva

bind cpw_unit cpw_sva i_cpw_sva (.ref_clk(ref_clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .unitPinOut(unitPinOut), .unitPinOe(unitPinOe),
    .adcEnable(adcEnable), .adcStart(adcStart));

// ### tb/cpw_pin_model.sv
`timescale 1ns/10ps
module cpw_pin_model (
    // clock
    input  wire logic ref_clk,
    // unit side
    input  wire logic pinOut,
    input  wire logic pinOe,
    // resolved pin
    output logic      pinWire
);
    logic srcQ = 1'b0;
    int   highCnt = 0;
    // unit wins the wire while it drives
    assign pinWire = pinOe ? pinOut : srcQ;
    always @(posedge ref_clk) begin
        if (pinOe && pinOut)
            highCnt <= highCnt + 1;
    end
    task automatic rises(input int n, input int gap);
        repeat (n) begin
            srcQ <= 1'b1;
            repeat (gap) @(posedge ref_clk);
            srcQ <= 1'b0;
            repeat (gap) @(posedge ref_clk);
        end
    endtask : rises
endmodule : cpw_pin_model

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import cpw_pkg::*;
    logic              ref_clk, reset, read, write, timer1Tick, adcEnable;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata, readdata;
    logic              waitrequest, pinWire, unitPinOut, unitPinOe, adcStart;
    int                err_total = 0, tests_run = 0, cycles = 0, adcSeen = 0, seed, m0;
    logic [31:0]       d;
    logic [7:0]        rd;
    logic [7:0]        regIdx [5] = '{IDX_CONTROL, IDX_T2_CONTROL, IDX_T2_COUNT, IDX_T2_PERIOD, 8'h20};
    logic [7:0]        regRst [5] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
    logic [3:0]        capM [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int                capN [4] = '{1, 1, 4, 16};
    logic [3:0]        cmpM [5] = '{4'h8, 4'h9, 4'hB, 4'h8, 4'hA};
    logic [9:0]        duty [6] = '{10'h0, 10'h1, 10'hF, 10'h14, 10'h10, 10'h0};
    cpw_unit i_cpw_unit (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .unitPinIn(pinWire), .unitPinOut(unitPinOut), .unitPinOe(unitPinOe),
        .timer1Tick(timer1Tick), .adcEnable(adcEnable), .adcStart(adcStart));
    cpw_pin_model i_cpw_pin_model (.ref_clk(ref_clk), .pinOut(unitPinOut), .pinOe(unitPinOe),
        .pinWire(pinWire));
    // ----
    // clock, timeout and helpers
    // ----
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (adcStart === 1'b1)
            adcSeen <= adcSeen + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] data);
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, data};
        read <= !wr;
        write <= wr;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            timer1Tick <= 1'b1;
            @(posedge ref_clk);
            timer1Tick <= 1'b0;
        end
    endtask : tick
    task automatic capSeq(input logic [3:0] m1, input int pre, input logic [3:0] m2,
                          input logic viaZero, input int n);
        bus(1, IDX_CONTROL, 8'h00);
        bus(1, IDX_CONTROL, {4'h0, m1});
        i_cpw_pin_model.rises(pre, 2);
        if (viaZero)
            bus(1, IDX_CONTROL, 8'h00);
        bus(1, IDX_CONTROL, {4'h0, m2});
        bus(1, IDX_IRQ_FLAGS, 8'h00);
        i_cpw_pin_model.rises(n - 1, 3);
        bus(0, IDX_IRQ_FLAGS, 8'h00);
        check(rd, 8'h00);
        i_cpw_pin_model.rises(1, 3);
        bus(0, IDX_IRQ_FLAGS, 8'h00);
        check(rd, 8'h04);
    endtask : capSeq
    function automatic logic [31:0] pwmHigh(input logic [9:0] dv);
        return dv == 10'h0 ? 0 : dv >= 10'h10 ? 64 : 4 * dv;
    endfunction : pwmHigh
    // ----
    // main sequence
    // ----
    initial begin
        seed = 19680;
        {address, read, write, writedata, timer1Tick} = '0;
        adcEnable = 1'b1;
        reset = 1'b1;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        bus(1, 8'h20, 8'hA5);
        foreach (regIdx[i]) begin
            bus(0, regIdx[i], 8'h00);
            check(rd, regRst[i]);
        end
        foreach (capM[i]) begin
            d = $random(seed);
            bus(1, IDX_T1_LOW, d[7:0]);
            bus(1, IDX_T1_HIGH, d[15:8]);
            capSeq(capM[i], 0, capM[i], 1'b0, capN[i]);
            bus(0, IDX_VALUE_LOW, 8'h00);
            check(rd, d[7:0]);
            bus(0, IDX_VALUE_HIGH, 8'h00);
            check(rd, d[15:8]);
        end
        capSeq(4'h6, 2, 4'h7, 1'b0, 14);
        capSeq(4'h6, 2, 4'h6, 1'b1, 4);
        bus(1, IDX_VALUE_LOW, 8'h34);
        bus(1, IDX_VALUE_HIGH, 8'h12);
        foreach (cmpM[i]) begin
            bus(1, IDX_T1_LOW, 8'h31);
            bus(1, IDX_T1_HIGH, 8'h12);
            bus(1, IDX_CONTROL, {4'h0, cmpM[i]});
            bus(1, IDX_IRQ_FLAGS, 8'h00);
            tick(3);
            repeat (3) @(posedge ref_clk);
            check(unitPinOut, i == 1 || i == 2 ? 1'b0 : 1'b1);
            bus(0, IDX_IRQ_FLAGS, 8'h00);
            check(rd, 8'h04);
            bus(0, IDX_T1_LOW, 8'h00);
            check(rd, cmpM[i] == MODE_CMP_TRIG ? 8'h00 : 8'h34);
        end
        check(adcSeen, 1);
        bus(1, IDX_CONTROL, 8'h00);
        repeat (3) @(posedge ref_clk);
        check(unitPinOut, 1'b0);
        d = $random(seed);
        duty[5] = {6'h0, d[3:0]};
        bus(1, IDX_T2_PERIOD, 8'h03);
        bus(1, IDX_VALUE_LOW, 8'h00);
        bus(1, IDX_T2_CONTROL, {1'b0, d[7:4], 3'b100});
        foreach (duty[i]) begin
            bus(1, IDX_VALUE_LOW, duty[i][9:2]);
            bus(1, IDX_CONTROL, {2'b00, duty[i][1:0], 4'hC});
            bus(1, IDX_VALUE_HIGH, 8'hAA);
            repeat (40) @(posedge ref_clk);
            m0 = i_cpw_pin_model.highCnt;
            repeat (64) @(posedge ref_clk);
            check(i_cpw_pin_model.highCnt - m0, pwmHigh(duty[i]));
            check(unitPinOe, 1'b1);
            bus(0, IDX_VALUE_HIGH, 8'h00);
            check(rd, duty[i][9:2]);
        end
        final_report();
    end
endmodule : testbench
